// File: configurable_parameter_map_tb.sv
`timescale 1ns/1ps
module configurable_parameter_map_tb;
   import cpm_pkg::*;
   logic          sys_clk = 1'b0;
   logic          reset_n, req_valid, req_write, req_ready, resp_valid, resp_err, resp_binary;
   logic          tag_sel, tag_wr, tag_writable, tag_run_locked, tag_binary, drive_running;
   logic          padded_binary_reply_enable, large_rating, main_serial_port_parity_odd;
   logic          keypad_odd_select, keypad_even_select;
   logic [7:0]    req_addr, tag_num;
   logic [15:0]   req_wvalue, resp_value, tag_wdata, tag_rdata, tag_reserved_mask;
   logic [15:0]   tag_min, tag_max;
   logic [2:0]    req_wlen, resp_len;
   cpm_chars_t    req_wchars, resp_chars;
   cpm_ptr_table_t pointer_table;
   int            err_count = 0;
   int            tests_run = 0;
   always #5 sys_clk = ~sys_clk;
   cpm_param_map #(.SWFREQ_TAG(8'h00)) dut_u (.*);
   cpm_tag_store store_u (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One access, entered and left at a falling edge, answer held afterwards
   task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] v,
                      input cpm_chars_t ch = '0, input logic [2:0] len = 3'h0);
      int n = 0;
      req_write = wr;
      req_addr = a;
      req_wvalue = v;
      req_wchars = ch;
      req_wlen = len;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 20) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      req_valid = 1'b0;
      while (resp_valid !== 1'b1 && n < 40) begin
         @(negedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      if (n >= 40) chk("answer", 32'h1, 32'h0);
   endtask
   task automatic wr_exp(input logic [7:0] a, input logic [15:0] v, input logic e);
      acc(1'b1, a, v);
      chk("write_err", 32'(e), 32'(resp_err));
   endtask
   task automatic t_parity;
      chk("par_reset", 32'h0, 32'(main_serial_port_parity_odd));
      keypad_odd_select = 1'b1;
      @(negedge sys_clk);
      keypad_odd_select = 1'b0;
      chk("par_odd", 32'h1, 32'(main_serial_port_parity_odd));
      keypad_even_select = 1'b1;
      @(negedge sys_clk);
      chk("par_even", 32'h0, 32'(main_serial_port_parity_odd));
      keypad_odd_select = 1'b1;
      @(negedge sys_clk);
      keypad_odd_select = 1'b0;
      keypad_even_select = 1'b0;
      chk("par_both", 32'h1, 32'(main_serial_port_parity_odd));
      $display("done parity");
   endtask
   task automatic t_slots;
      for (int i = 0; i < 16; i++) pointer_table[i] = 8'h40 + 8'(i);
      for (int i = 0; i < 16; i++) begin
         acc(1'b0, CPM_SLOT_FIRST_ADDR + 8'(i), 16'h0);
         chk("slot", 32'(8'h40 + 8'(i)), 32'(resp_value));
      end
      pointer_table[3] = 8'h4a;
      acc(1'b0, CONFIG_SLOT_04, 16'h0);
      chk("repoint", 32'h4a, 32'(resp_value));
      $display("done slots");
   endtask
   task automatic t_binary;
      pointer_table[0] = 8'h05;
      acc(1'b1, CONFIG_SLOT_01, 16'h1, {8'h00, 8'h00, 8'h30, 8'h30}, 3'h2);
      acc(1'b0, CONFIG_SLOT_01, 16'h0);
      chk("short_len", 32'h1, 32'(resp_len));
      chk("short_chr", 32'h30, 32'(resp_chars[0]));
      padded_binary_reply_enable = 1'b1;
      acc(1'b1, CONFIG_SLOT_01, 16'h0, {8'h31, 8'h30, 8'h30, 8'h30}, 3'h4);
      acc(1'b0, CONFIG_SLOT_01, 16'h0);
      chk("padded", 32'h31303030, 32'(resp_chars));
      chk("padded_len", 32'h4, 32'(resp_len));
      chk("bin_flag", 32'h1, 32'(resp_binary));
      acc(1'b1, CONFIG_SLOT_01, 16'h0, {8'h30, 8'h30, 8'h30, 8'h31}, 3'h2);
      chk("bin_bad", 32'h1, 32'(resp_err));
      acc(1'b0, CONFIG_SLOT_01, 16'h0);
      chk("bad_keep", 32'h31303030, 32'(resp_chars));
      $display("done binary");
   endtask
   task automatic t_reserved;
      pointer_table[1] = 8'h10;
      acc(1'b0, CONFIG_SLOT_02, 16'h0);
      chk("rsv_poll", 32'h0123, 32'(resp_value));
      chk("num_len", 32'h0, 32'(resp_len));
      chk("num_flag", 32'h0, 32'(resp_binary));
      wr_exp(CONFIG_SLOT_02, 16'hf055, 1'b0);
      acc(1'b0, CONFIG_SLOT_02, 16'h0);
      chk("rsv_wr", 32'h0055, 32'(resp_value));
      drive_running = 1'b1;
      wr_exp(CONFIG_SLOT_02, 16'h0077, 1'b1);
      acc(1'b0, CONFIG_SLOT_02, 16'h0);
      chk("lock_keep", 32'h0055, 32'(resp_value));
      drive_running = 1'b0;
      $display("done reserved");
   endtask
   task automatic t_limits;
      pointer_table[2] = 8'h20;
      pointer_table[3] = 8'h21;
      pointer_table[4] = 8'h00;
      wr_exp(CONFIG_SLOT_03, 16'h0001, 1'b1);
      wr_exp(CONFIG_SLOT_04, 16'h000f, 1'b1);
      wr_exp(CONFIG_SLOT_04, 16'h0021, 1'b1);
      wr_exp(CONFIG_SLOT_04, 16'h0020, 1'b0);
      large_rating = 1'b1;
      wr_exp(CONFIG_SLOT_05, 16'h1771, 1'b1);
      wr_exp(CONFIG_SLOT_05, 16'h1770, 1'b0);
      large_rating = 1'b0;
      wr_exp(CONFIG_SLOT_05, 16'h1771, 1'b0);
      wr_exp(CPM_PTR_FIRST_ADDR, 16'h0000, 1'b1);
      $display("done limits");
   endtask
   initial begin
      {reset_n, req_valid, req_write, drive_running, large_rating} = '0;
      {padded_binary_reply_enable, keypad_odd_select, keypad_even_select} = '0;
      {req_addr, req_wvalue, req_wchars, req_wlen, pointer_table} = '0;
      repeat (16) @(negedge sys_clk);
      reset_n = 1'b1;
      t_parity;
      t_slots;
      t_binary;
      t_reserved;
      t_limits;
      give_verdict;
   end
   initial begin
      #50us;
      err_count++;
      give_verdict;
   end
endmodule

// File: cpm_bin_if.sv
`timescale 1ns/1ps
interface cpm_bin_if;
   import cpm_pkg::*;

   logic                state_bit;
   logic                padded_en;
   cpm_chars_t          wr_chars;
   logic [2:0]          wr_len;
   cpm_chars_t          reply_chars;
   logic [2:0]          reply_len;
   logic                dec_bit;
   logic                dec_ok;

   modport fmt (
      input  state_bit,
      input  padded_en,
      input  wr_chars,
      input  wr_len,
      output reply_chars,
      output reply_len,
      output dec_bit,
      output dec_ok
   );

   modport user (
      output state_bit,
      output padded_en,
      output wr_chars,
      output wr_len,
      input  reply_chars,
      input  reply_len,
      input  dec_bit,
      input  dec_ok
   );
endinterface

// File: cpm_binfmt.sv
`timescale 1ns/1ps
module cpm_binfmt (
   cpm_bin_if.fmt bin
);
   import cpm_pkg::*;

   // Reply field for a two-state value
   always_comb begin
      bin.reply_chars = '{default: CPM_CHAR_ZERO};
      if (bin.padded_en) begin
         bin.reply_len      = CPM_LEN_PADDED;                       // [R6]
         bin.reply_chars[3] = bin.state_bit ? CPM_CHAR_ONE : CPM_CHAR_ZERO;
      end else begin
         bin.reply_len      = CPM_LEN_SHORT;                        // [R5]
         bin.reply_chars[0] = bin.state_bit ? CPM_CHAR_ONE : CPM_CHAR_ZERO;
      end
   end

   // Leading zeros skipped; what remains must be empty, 0 or 1
   always_comb begin
      logic       seen;
      logic [2:0] rest;
      logic       last;
      seen = 1'b0;
      rest = 3'h0;
      last = 1'b0;
      for (int i = 0; i < CPM_FIELD_MAX; i++) begin
         if (3'(i) < bin.wr_len) begin
            if (seen || bin.wr_chars[i] != CPM_CHAR_ZERO) begin     // [R7]
               seen = 1'b1;
               rest = rest + 3'h1;
               last = (bin.wr_chars[i] == CPM_CHAR_ONE);
            end
         end
      end
      bin.dec_bit = last;
      bin.dec_ok  = (bin.wr_len != 3'h0) && (rest == 3'h0 || (rest == 3'h1 && last));
   end
endmodule

// File: cpm_param_map.sv
`timescale 1ns/1ps
// Overview of operation
// [R1] Sixteen slots at 70..7F hex, slot n served by pointer n in order.
// [R2] Each slot resolves to the tag held in its pointer (pointer addresses 60..6F hex).
// [R3] Every slot access uses the target tag's rights, format and limits.
// [R4] Two-state tags get the selectable reply format only through the slots.
// [R5] Padded option off: a two-state poll returns one character, 0 or 1.
// [R6] Padded option on: a two-state poll returns 0,0,0 then the state.
// [R7] On a write to a two-state tag, leading zero characters are discarded.
// [R8] Serial port parity is even after reset and goes odd on keypad selection.
// [R9] Reserved bits read as zero and written values there are ignored.
// [R10] Run-locked tags accept writes only while the drive is stopped.
// [R11] Switching frequency is capped at 6 kHz on the larger ratings.
// [R12] The pointer is read again on every slot access.
module cpm_param_map #(
   parameter logic [7:0] SWFREQ_TAG = 8'h00
) (
   input  wire  logic                      sys_clk,
   input  wire  logic                      reset_n,
   input  wire  logic                      req_valid,
   input  wire  logic                      req_write,
   input  wire  logic [7:0]                req_addr,
   input  wire  logic [15:0]               req_wvalue,
   input  wire  cpm_pkg::cpm_chars_t       req_wchars,
   input  wire  logic [2:0]                req_wlen,
   output logic                            req_ready,
   output logic                            resp_valid,
   output logic                            resp_err,
   output logic [15:0]                     resp_value,
   output cpm_pkg::cpm_chars_t             resp_chars,
   output logic [2:0]                      resp_len,
   output logic                            resp_binary,
   input  wire  cpm_pkg::cpm_ptr_table_t   pointer_table,
   output logic                            tag_sel,
   output logic [7:0]                      tag_num,
   output logic                            tag_wr,
   output logic [15:0]                     tag_wdata,
   input  wire  logic [15:0]               tag_rdata,
   input  wire  logic                      tag_writable,
   input  wire  logic                      tag_run_locked,
   input  wire  logic                      tag_binary,
   input  wire  logic [15:0]               tag_reserved_mask,
   input  wire  logic [15:0]               tag_min,
   input  wire  logic [15:0]               tag_max,
   input  wire  logic                      padded_binary_reply_enable,
   input  wire  logic                      drive_running,
   input  wire  logic                      large_rating,
   input  wire  logic                      keypad_odd_select,
   input  wire  logic                      keypad_even_select,
   output logic                            main_serial_port_parity_odd
);
   import cpm_pkg::*;

   function automatic logic is_slot(input logic [7:0] a);
      is_slot = (a >= CPM_SLOT_FIRST_ADDR) && (a <= CPM_SLOT_LAST_ADDR);
   endfunction

   function automatic logic [CPM_SLOT_IDX_W-1:0] slot_index(input logic [7:0] a);
      logic [7:0] d;
      d = a - CPM_SLOT_FIRST_ADDR;
      slot_index = d[CPM_SLOT_IDX_W-1:0];
   endfunction

   cpm_state_t  state,      next_state;
   logic        wr_q,       next_wr_q;
   logic [15:0] wval_q,     next_wval_q;
   cpm_chars_t  wchars_q,   next_wchars_q;
   logic [2:0]  wlen_q,     next_wlen_q;
   logic        req_ready_n;
   logic        next_tag_sel, next_tag_wr, next_resp_valid, next_resp_err;
   logic [7:0]  next_tag_num;
   logic [15:0] next_tag_wdata, next_resp_value;
   cpm_chars_t  next_resp_chars;
   logic [2:0]  next_resp_len;
   logic        next_resp_binary, next_parity_odd;

   cpm_bin_if bin ();

   cpm_binfmt u_binfmt (
      .bin (bin.fmt)
   );

   assign bin.state_bit = tag_rdata[0];
   assign bin.padded_en = padded_binary_reply_enable;
   assign bin.wr_chars  = wchars_q;
   assign bin.wr_len    = wlen_q;

   ////////////////////////////////////////////////////////////////////////////
   // Access sequencer

   always_comb begin
      logic [15:0] val;
      logic [15:0] hi;
      logic        ok;
      next_state       = state;
      next_wr_q        = wr_q;
      next_wval_q      = wval_q;
      next_wchars_q    = wchars_q;
      next_wlen_q      = wlen_q;
      req_ready_n      = 1'b0;
      next_tag_sel     = 1'b0;
      next_tag_num     = tag_num;
      next_tag_wr      = 1'b0;
      next_tag_wdata   = tag_wdata;
      next_resp_valid  = 1'b0;
      next_resp_err    = resp_err;
      next_resp_value  = resp_value;
      next_resp_chars  = resp_chars;
      next_resp_len    = resp_len;
      next_resp_binary = resp_binary;
      val = 16'h0000;
      hi  = 16'h0000;
      ok  = 1'b0;
      case (state)
         CPM_IDLE: begin
            if (req_valid) begin
               req_ready_n   = 1'b1;
               next_wr_q     = req_write;
               next_wval_q   = req_wvalue;
               next_wchars_q = req_wchars;
               next_wlen_q   = req_wlen;
               if (is_slot(req_addr)) begin                              // [R1]
                  // Fresh pointer fetch every access
                  next_tag_num = pointer_table[slot_index(req_addr)];   // [R2] [R12]
                  next_tag_sel = 1'b1;
                  next_state   = CPM_LOOK;
               end else begin
                  next_resp_err   = 1'b1;
                  next_resp_value = 16'h0000;
                  next_resp_len   = 3'h0;
                  next_resp_valid = 1'b1;
                  next_state      = CPM_DONE;
               end
            end
         end
         CPM_LOOK: begin
            next_resp_binary = tag_binary;                              // [R4]
            if (!wr_q) begin
               next_resp_value = tag_rdata & ~tag_reserved_mask;         // [R3] [R9]
               if (tag_binary) begin
                  next_resp_chars = bin.reply_chars;                     // [R5] [R6]
                  next_resp_len   = bin.reply_len;
               end else begin
                  next_resp_chars = '{default: CPM_CHAR_ZERO};
                  next_resp_len   = 3'h0;
               end
               next_resp_err = 1'b0;
            end else begin
               val = tag_binary ? {15'h0000, bin.dec_bit} : wval_q;      // [R7]
               hi  = tag_max;
               if (large_rating && tag_num == SWFREQ_TAG &&
                   hi > CPM_SWFREQ_CAP_LARGE) begin
                  hi = CPM_SWFREQ_CAP_LARGE;                             // [R11]
               end
               ok = tag_writable && !(tag_run_locked && drive_running);   // [R3] [R10]
               if (tag_binary) begin
                  ok = ok && bin.dec_ok;
               end else begin
                  ok = ok && val >= tag_min && val <= hi;                // [R3]
               end
               next_tag_wr     = ok;
               // Reserved bits are written as zero
               next_tag_wdata  = val & ~tag_reserved_mask;               // [R9]
               next_resp_err   = !ok;
               next_resp_value = 16'h0000;
               next_resp_len   = 3'h0;
            end
            next_resp_valid = 1'b1;
            next_state      = CPM_DONE;
         end
         CPM_DONE: begin
            next_state = CPM_IDLE;
         end
         default: begin
            next_state = CPM_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state       <= CPM_IDLE;
         wr_q        <= 1'b0;
         wval_q      <= 16'h0000;
         wchars_q    <= '{default: 8'h00};
         wlen_q      <= 3'h0;
         req_ready   <= 1'b1;
         tag_sel     <= 1'b0;
         tag_num     <= 8'h00;
         tag_wr      <= 1'b0;
         tag_wdata   <= 16'h0000;
         resp_valid  <= 1'b0;
         resp_err    <= 1'b0;
         resp_value  <= 16'h0000;
         resp_chars  <= '{default: 8'h00};
         resp_len    <= 3'h0;
         resp_binary <= 1'b0;
      end else begin
         state       <= next_state;
         wr_q        <= next_wr_q;
         wval_q      <= next_wval_q;
         wchars_q    <= next_wchars_q;
         wlen_q      <= next_wlen_q;
         req_ready   <= (next_state == CPM_IDLE) && !req_ready_n;
         tag_sel     <= next_tag_sel;
         tag_num     <= next_tag_num;
         tag_wr      <= next_tag_wr;
         tag_wdata   <= next_tag_wdata;
         resp_valid  <= next_resp_valid;
         resp_err    <= next_resp_err;
         resp_value  <= next_resp_value;
         resp_chars  <= next_resp_chars;
         resp_len    <= next_resp_len;
         resp_binary <= next_resp_binary;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial port parity selection

   always_comb begin
      next_parity_odd = main_serial_port_parity_odd;
      if (keypad_odd_select) begin
         next_parity_odd = 1'b1;                                        // [R8]
      end else if (keypad_even_select) begin
         next_parity_odd = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         main_serial_port_parity_odd <= CPM_PARITY_ODD_RST;             // [R8]
      end else begin
         main_serial_port_parity_odd <= next_parity_odd;
      end
   end
endmodule

// File: cpm_param_map_props.sv
`timescale 1ns/1ps
module cpm_param_map_props (
   input wire logic                    sys_clk,
   input wire logic                    reset_n,
   input wire logic                    req_valid,
   input wire logic                    req_write,
   input wire logic [7:0]              req_addr,
   input wire logic                    req_ready,
   input wire logic                    resp_valid,
   input wire logic                    resp_err,
   input wire logic [2:0]              resp_len,
   input wire logic                    resp_binary,
   input wire cpm_pkg::cpm_ptr_table_t pointer_table,
   input wire logic                    tag_sel,
   input wire logic [7:0]              tag_num,
   input wire logic                    tag_wr,
   input wire logic [15:0]             tag_wdata,
   input wire logic                    tag_writable,
   input wire logic                    tag_run_locked,
   input wire logic [15:0]             tag_reserved_mask,
   input wire logic                    padded_binary_reply_enable,
   input wire logic                    drive_running,
   input wire logic                    keypad_odd_select,
   input wire logic                    main_serial_port_parity_odd
);
   import cpm_pkg::*;
   logic       wr_q;
   logic       next_wr_q;
   logic [7:0] exp_tag;
   logic [7:0] next_exp_tag;
   wire        take = req_valid && req_ready;
   wire        slot = req_addr[7:4] == 4'h7;
   ////////////////////////////////////////////////////////////////////////////////
   // Request kind and pointed tag at take time
   always_comb begin
      next_wr_q = take ? req_write : wr_q;
      next_exp_tag = take ? pointer_table[req_addr[3:0]] : exp_tag;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= 1'b0;
         exp_tag <= 8'h00;
      end else begin
         wr_q <= next_wr_q;
         exp_tag <= next_exp_tag;
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_take_slot; take && slot; endsequence
   sequence s_take_other; take && !slot; endsequence
   sequence s_wr_look; tag_sel && wr_q; endsequence
   property p_tag_pick; s_take_slot |=> tag_sel && tag_num == exp_tag; endproperty
   property p_slot_answer; s_take_slot |=> !req_ready ##1 resp_valid; endproperty
   property p_unmapped; s_take_other |=> resp_valid && resp_err; endproperty
   property p_run_lock;
      s_wr_look ##0 (tag_run_locked && drive_running) |=> resp_err && !tag_wr;
   endproperty
   property p_read_only; s_wr_look ##0 !tag_writable |=> resp_err && !tag_wr; endproperty
   property p_reserved; tag_wr |-> (tag_wdata & tag_reserved_mask) == 16'h0000; endproperty
   property p_bin_len;
      resp_valid && resp_binary && !resp_err && !wr_q |->
         resp_len == ($past(padded_binary_reply_enable) ? CPM_LEN_PADDED : CPM_LEN_SHORT);
   endproperty
   property p_parity_odd; keypad_odd_select |=> main_serial_port_parity_odd; endproperty
   a_tag_pick: assert property (p_tag_pick) else $error("wrong tag");
   a_slot_answer: assert property (p_slot_answer) else $error("slot answer late");
   a_unmapped: assert property (p_unmapped) else $error("unmapped accepted");
   a_run_lock: assert property (p_run_lock) else $error("locked write taken");
   a_read_only: assert property (p_read_only) else $error("read-only written");
   a_reserved: assert property (p_reserved) else $error("reserved bits written");
   a_bin_len: assert property (p_bin_len) else $error("binary length wrong");
   a_parity_odd: assert property (p_parity_odd) else $error("parity not odd");
endmodule
bind cpm_param_map cpm_param_map_props chk_u (.*);

// File: cpm_pkg.sv
package cpm_pkg;

   // Parameter serial addresses (mnemonics)
   localparam logic [7:0] CPM_SLOT_FIRST_ADDR = 8'h70;
   localparam logic [7:0] CPM_SLOT_LAST_ADDR  = 8'h7f;
   localparam logic [7:0] CPM_PTR_FIRST_ADDR  = 8'h60;
   localparam int         CPM_NUM_SLOTS       = 16;
   localparam int         CPM_SLOT_IDX_W      = 4;
   localparam int         CPM_TAG_W           = 8;
   localparam int         CPM_DATA_W          = 16;

   // Register offsets of the sixteen slots
   localparam logic [7:0] CONFIG_SLOT_01 = 8'h70;
   localparam logic [7:0] CONFIG_SLOT_02 = 8'h71;
   localparam logic [7:0] CONFIG_SLOT_03 = 8'h72;
   localparam logic [7:0] CONFIG_SLOT_04 = 8'h73;
   localparam logic [7:0] CONFIG_SLOT_05 = 8'h74;
   localparam logic [7:0] CONFIG_SLOT_06 = 8'h75;
   localparam logic [7:0] CONFIG_SLOT_07 = 8'h76;
   localparam logic [7:0] CONFIG_SLOT_08 = 8'h77;
   localparam logic [7:0] CONFIG_SLOT_09 = 8'h78;
   localparam logic [7:0] CONFIG_SLOT_10 = 8'h79;
   localparam logic [7:0] CONFIG_SLOT_11 = 8'h7a;
   localparam logic [7:0] CONFIG_SLOT_12 = 8'h7b;
   localparam logic [7:0] CONFIG_SLOT_13 = 8'h7c;
   localparam logic [7:0] CONFIG_SLOT_14 = 8'h7d;
   localparam logic [7:0] CONFIG_SLOT_15 = 8'h7e;
   localparam logic [7:0] CONFIG_SLOT_16 = 8'h7f;

   // Data field characters
   localparam logic [7:0] CPM_CHAR_ZERO  = 8'h30;
   localparam logic [7:0] CPM_CHAR_ONE   = 8'h31;
   localparam int         CPM_FIELD_MAX  = 4;
   localparam logic [2:0] CPM_LEN_SHORT  = 3'h1;
   localparam logic [2:0] CPM_LEN_PADDED = 3'h4;

   // Switching-frequency cap, value in Hz: 6 kHz
   localparam logic [15:0] CPM_SWFREQ_CAP_LARGE = 16'h1770;

   // Reset values
   localparam logic CPM_PARITY_ODD_RST = 1'b0;

   typedef logic [CPM_NUM_SLOTS-1:0][CPM_TAG_W-1:0] cpm_ptr_table_t;
   typedef logic [CPM_FIELD_MAX-1:0][7:0]           cpm_chars_t;

   typedef enum logic [1:0] {
      CPM_IDLE = 2'b00,
      CPM_LOOK = 2'b01,
      CPM_DONE = 2'b11
   } cpm_state_t;

endpackage

// File: cpm_tag_store.sv
`timescale 1ns/1ps
module cpm_tag_store (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  tag_num,
   input  wire logic        tag_wr,
   input  wire logic [15:0] tag_wdata,
   output logic [15:0]      tag_rdata,
   output logic             tag_writable,
   output logic             tag_run_locked,
   output logic             tag_binary,
   output logic [15:0]      tag_reserved_mask,
   output logic [15:0]      tag_min,
   output logic [15:0]      tag_max
);
   logic [15:0] mem [256];
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'(i);
      mem[8'h10] = 16'hf123;
   end
   // Attributes follow the addressed tag only
   always_comb begin
      tag_rdata = mem[tag_num];
      tag_writable = tag_num != 8'h20;
      tag_run_locked = tag_num == 8'h10;
      tag_binary = tag_num == 8'h05;
      tag_reserved_mask = (tag_num == 8'h10) ? 16'hf000 : 16'h0000;
      tag_min = (tag_num == 8'h21) ? 16'h0010 : 16'h0000;
      tag_max = (tag_num == 8'h21) ? 16'h0020 : 16'hffff;
   end
   always @(posedge sys_clk) if (tag_wr) mem[tag_num] <= tag_wdata;
endmodule
